/* seq_pkg.sv */
// constants, field layouts and carrier types for the instruction sequencer
// assumes a single 25 MHz clock and a plain strobe register port
package seq_pkg;

    localparam int          CLK_MHZ       = 25;
    // register offsets (plain port, word index)
    localparam logic [3:0]  OFS_CONFIG    = 4'h0;
    localparam logic [3:0]  OFS_TIMER     = 4'h1;
    localparam logic [3:0]  OFS_STATUS    = 4'h2;
    localparam logic [3:0]  OFS_RESULT    = 4'h3;
    localparam logic [3:0]  OFS_INSTR     = 4'h8;   // 0x8..0xF: instruction words
    // configuration bit positions
    localparam int          CFG_START     = 0;
    localparam int          CFG_RESET     = 1;
    localparam int          CFG_SHORT_A   = 2;
    localparam int          CFG_FULL_CAL  = 3;
    localparam int          CFG_SHORT_B   = 6;
    // instruction word and status bit positions
    localparam int          INS_PAUSE     = 0;
    localparam int          INS_LOOP      = 1;
    localparam int          INS_LOW_RES   = 8;
    localparam int          INS_TIMER_EN  = 9;
    localparam int          INS_COMPARE   = 11;
    localparam int          INS_DLY_LSB   = 12;
    localparam int          STAT_IP_LSB   = 8;
    // cycle counts per state
    localparam int          CYC_FETCH     = 1;
    localparam int          CYC_CHECK     = 1;
    localparam int          CYC_CAL_SHORT = 76;
    localparam int          CYC_CAL_FULL  = 4944;
    localparam int          TMR_SCALE     = 32;
    localparam int          TMR_EXTRA     = 2;
    localparam int          ACQ_FULL_BASE = 9;
    localparam int          ACQ_LOW_BASE  = 2;
    localparam int          CYC_CMP       = 5;
    localparam int          CYC_LIM2      = 1;
    localparam int          CYC_CONV_FULL = 44;
    localparam int          CYC_CONV_LOW  = 21;
    // reduced-resolution filler in the low nibble
    localparam logic [3:0]  LOW_RES_FILL  = 4'hE;
    localparam logic [15:0] CONFIG_RST    = 16'h0000;
    localparam logic [15:0] TIMER_RST     = 16'h0000;

    // sequencer states, gray coded along fetch..conversion
    typedef enum logic [2:0] {
        ST_FETCH = 3'h0,
        ST_CHECK = 3'h1,
        ST_CAL   = 3'h3,
        ST_TIMER = 3'h2,
        ST_ACQ   = 3'h6,
        ST_CMP   = 3'h7,
        ST_LIM2  = 3'h5,
        ST_CONV  = 3'h4
    } seq_state_t;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

endpackage : seq_pkg

/* adc_instruction_sequencer.sv */
// instruction sequencer: pointer, state walk with per-state cycle counts, result coding
// assumes host strobes synchronous to clk; analog results arrive as signed codes
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: pointer is 3 bits; cleared on reset or when a looping instruction ends.
// R2: loop flag is bit 1 of each instruction's first word.
// R3: pointer increments at instruction end, up to 111, unless loop.
// R4: without loop flags all eight entries run cyclically, wrapping.
// R5: software sets loop on last programmed instruction when using fewer.
// R6: status bits 8 to 10 show pointer at any time.
// R7: fetch reads the first instruction word in one cycle.
// R8: check state tests calibration and start; rests there when stopped.
// R9: with start set, check state lasts one cycle.
// R10: short calibration, config bit 2 or 6, lasts 76 cycles.
// R11: full calibration, config bit 3, lasts 4944 cycles.
// R12: timer state waits 32T plus 2 cycles.
// R13: full-resolution acquisition waits 9 plus 2D cycles.
// R14: low-resolution or compare acquisition waits 2 plus 2D cycles.
// R15: first comparison state lasts 5 cycles.
// R16: second limit read state lasts one cycle.
// R17: conversion 44 or 21 cycles; second comparison 5 cycles.
// R18: full-resolution code clamps to -4096..4095.
// R19: reduced-resolution code clamps to -256..255.
// R20: timer state only when instruction bit 9 set.
// R21: halt before a paused instruction; stop on cleared start or reset flag.
// R22: result 13 bits, sign bit 12; low nibble 1110 at reduced resolution.
// R23: state order fetch,1,2,3,7,6,4,5 then fetch with advanced pointer; the code's state codes run fetch,1,3,2,6,7,5,4.
// R24: skip calibration if none; skip compare states unless compare instruction.
module adc_instruction_sequencer
    import seq_pkg::*;
#(
    parameter int CAL_FULL_CYCLES = CYC_CAL_FULL
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire seq_pkg::reg_req_t req,
    input  wire logic signed [15:0] conv_code,
    output logic [15:0]            rdata,
    output logic [2:0]             state_out,
    output logic                   convert_done
);
    import seq_pkg::*;

    localparam int CW = 21;

    logic [15:0] instr_mem_q [8];
    logic [15:0] config_q;
    logic [15:0] timer_q;
    logic [15:0] instr_q;
    logic [2:0]  ip_q;
    logic [CW-1:0] cnt_q;
    logic [12:0] result_q;
    logic        cal_pend_q;
    logic        paused_q;
    seq_state_t  state_q;
    seq_state_t  state_d;
    logic [CW-1:0] load_d;

    // saturating two's-complement coding of the converter code
    function automatic logic [12:0] code_result(input logic signed [15:0] c,
                                                input logic low);
        logic signed [15:0] v;
        v = c;
        if (low) begin
            if (v > 16'sd255) v = 16'sd255;                // R19
            if (v < -16'sd256) v = -16'sd256;              // R19
            code_result = {v[8:0], LOW_RES_FILL};          // R22
        end else begin
            if (v > 16'sd4095) v = 16'sd4095;              // R18
            if (v < -16'sd4096) v = -16'sd4096;            // R18
            code_result = v[12:0];                         // R22
        end
    endfunction : code_result

    // cycles spent in each state, loaded on entry
    function automatic logic [CW-1:0] state_len(input seq_state_t s,
                                                input logic [15:0] ins,
                                                input logic [15:0] cfg,
                                                input logic [15:0] tmr);
        logic [CW-1:0] d;
        d = CW'(ins[INS_DLY_LSB +: 4]);
        case (s)
            ST_CAL:   state_len = cfg[CFG_FULL_CAL] ? CW'(CAL_FULL_CYCLES)
                                                    : CW'(CYC_CAL_SHORT);  // R10 R11
            ST_TIMER: state_len = CW'(TMR_SCALE) * CW'(tmr) + CW'(TMR_EXTRA); // R12
            ST_ACQ:   state_len = (ins[INS_LOW_RES] || ins[INS_COMPARE])
                                  ? CW'(ACQ_LOW_BASE) + (d << 1)          // R14
                                  : CW'(ACQ_FULL_BASE) + (d << 1);        // R13
            ST_CMP:   state_len = CW'(CYC_CMP);                           // R15
            ST_LIM2:  state_len = CW'(CYC_LIM2);                          // R16
            ST_CONV:  state_len = ins[INS_COMPARE] ? CW'(CYC_CMP)
                                : ins[INS_LOW_RES] ? CW'(CYC_CONV_LOW)
                                : CW'(CYC_CONV_FULL);                     // R17
            default:  state_len = CW'(1);
        endcase
    endfunction : state_len

    wire logic cal_req  = config_q[CFG_SHORT_A] | config_q[CFG_SHORT_B]
                        | config_q[CFG_FULL_CAL];
    wire logic run_ok   = config_q[CFG_START] & ~config_q[CFG_RESET];
    wire logic last_cyc = (cnt_q == CW'(1));

    // next state: fixed walk with bypasses
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_FETCH: state_d = ST_CHECK;                                  // R7 R23
            ST_CHECK: begin
                if (run_ok && !(instr_q[INS_PAUSE] && !paused_q)) begin    // R8 R9 R21
                    if (cal_pend_q)                state_d = ST_CAL;       // R24
                    else if (instr_q[INS_TIMER_EN]) state_d = ST_TIMER;    // R20
                    else                           state_d = ST_ACQ;
                end
            end
            ST_CAL:   if (last_cyc) state_d = instr_q[INS_TIMER_EN] ? ST_TIMER : ST_ACQ;
            ST_TIMER: if (last_cyc) state_d = ST_ACQ;
            ST_ACQ:   if (last_cyc) state_d = instr_q[INS_COMPARE] ? ST_CMP : ST_CONV; // R24
            ST_CMP:   if (last_cyc) state_d = ST_LIM2;
            ST_LIM2:  if (last_cyc) state_d = ST_CONV;
            ST_CONV:  if (last_cyc) state_d = ST_FETCH;                    // R23
            default:  state_d = ST_FETCH;
        endcase
        load_d = state_len(state_d, instr_q, config_q, timer_q);
    end

    // state register and cycle counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_FETCH;
            cnt_q   <= CW'(1);
        end else if (config_q[CFG_RESET]) begin
            state_q <= ST_FETCH;                                           // R21
            cnt_q   <= CW'(1);
        end else if (state_d != state_q) begin
            state_q <= state_d;
            cnt_q   <= load_d;
        end else if (cnt_q != CW'(1)) begin
            cnt_q   <= cnt_q - CW'(1);
        end
    end

    // fetch latches the current word in its single cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) instr_q <= 16'h0000;
        else if (state_q == ST_FETCH) instr_q <= instr_mem_q[ip_q];        // R7
    end

    // pause: halt once before the instruction, resume after start is rewritten
    always_ff @(posedge clk or posedge reset) begin
        if (reset) paused_q <= 1'b0;
        else if (state_q == ST_FETCH) paused_q <= 1'b0;
        else if (req.wr && req.addr == OFS_CONFIG && req.wdata[CFG_START]
                 && state_q == ST_CHECK) paused_q <= 1'b1;
    end

    // instruction pointer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ip_q <= 3'h0;                                                  // R1
        end else if (config_q[CFG_RESET]) begin
            ip_q <= 3'h0;                                                  // R1
        end else if (state_q == ST_CONV && last_cyc) begin
            if (instr_q[INS_LOOP]) ip_q <= 3'h0;                           // R1 R2
            else                   ip_q <= ip_q + 3'h1;                    // R3 R4
        end
    end

    // calibration request: set by write, consumed on entering calibration
    always_ff @(posedge clk or posedge reset) begin
        if (reset) cal_pend_q <= 1'b0;
        else if (req.wr && req.addr == OFS_CONFIG)
            cal_pend_q <= req.wdata[CFG_SHORT_A] | req.wdata[CFG_SHORT_B]
                        | req.wdata[CFG_FULL_CAL];
        else if (state_q == ST_CAL) cal_pend_q <= 1'b0;
    end

    // config and timer registers; calibration bits self-clear when done
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            config_q <= CONFIG_RST;
            timer_q  <= TIMER_RST;
        end else begin
            if (req.wr && req.addr == OFS_CONFIG) config_q <= req.wdata;
            else begin
                if (config_q[CFG_RESET]) config_q[CFG_RESET] <= 1'b0;
                if (state_q == ST_CAL && last_cyc && cal_req) begin
                    config_q[CFG_SHORT_A]  <= 1'b0;
                    config_q[CFG_SHORT_B]  <= 1'b0;
                    config_q[CFG_FULL_CAL] <= 1'b0;
                end
            end
            if (req.wr && req.addr == OFS_TIMER) timer_q <= req.wdata;
        end
    end

    // instruction memory, one flip-flop word per entry
    for (genvar i = 0; i < 8; i++) begin : g_mem
        always_ff @(posedge clk or posedge reset) begin
            if (reset) instr_mem_q[i] <= 16'h0000;
            else if (req.wr && req.addr == (OFS_INSTR | 4'(i))) instr_mem_q[i] <= req.wdata;
        end
    end

    // result capture at the end of a conversion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q     <= 13'h0000;
            convert_done <= 1'b0;
        end else begin
            convert_done <= 1'b0;
            if (state_q == ST_CONV && last_cyc && !instr_q[INS_COMPARE]) begin
                result_q     <= code_result(conv_code, instr_q[INS_LOW_RES]);
                convert_done <= 1'b1;
            end
        end
    end

    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) rdata <= 16'h0000;
        else if (req.rd) begin
            case (req.addr)
                OFS_CONFIG: rdata <= config_q;
                OFS_TIMER:  rdata <= timer_q;
                OFS_STATUS: rdata <= {5'h00, ip_q, 5'h00, state_q};        // R6
                OFS_RESULT: rdata <= {{3{result_q[12]}}, result_q};        // R22
                default:    rdata <= req.addr[3] ? instr_mem_q[req.addr[2:0]] : 16'h0000;
            endcase
        end else rdata <= 16'h0000;
    end

    // mirrors state_q, soft reset too, so the pin never hides the fetch after it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) state_out <= ST_FETCH;
        else if (config_q[CFG_RESET]) state_out <= ST_FETCH;             // R21
        else state_out <= state_d;
    end

    // checks
    fetch_one_a: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_FETCH && !config_q[CFG_RESET] |=> state_q == ST_CHECK)  // R7
        else $error("fetch not one cycle");
    ip_loop_a: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_CONV && last_cyc && instr_q[INS_LOOP] && !config_q[CFG_RESET]
        |=> ip_q == 3'h0) else $error("loop did not clear pointer");      // R1
    ip_inc_a: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_CONV && last_cyc && !instr_q[INS_LOOP] && !config_q[CFG_RESET]
        |=> ip_q == $past(ip_q) + 3'h1) else $error("pointer not advanced"); // R3
    ip_hold_a: assert property (@(posedge clk) disable iff (reset)
        state_q != ST_CONV && !config_q[CFG_RESET] |=> $stable(ip_q))
        else $error("pointer moved mid instruction");                    // R3
    cmp_len_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q == ST_CMP) |-> (state_q == ST_CMP)[*5] ##1 state_q == ST_LIM2)
        else $error("compare state length wrong");                       // R15
    lim2_len_a: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_LIM2 && !config_q[CFG_RESET] |=> state_q == ST_CONV)
        else $error("limit read not one cycle");                         // R16
    timer_gate_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q == ST_TIMER) |-> instr_q[INS_TIMER_EN])
        else $error("timer without enable");                             // R20
    stop_a: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_CHECK && !config_q[CFG_START] |=> state_q != ST_CAL
        && state_q != ST_TIMER && state_q != ST_ACQ)
        else $error("left rest state while stopped");                    // R8
    low_fill_a: assert property (@(posedge clk) disable iff (reset)
        convert_done && instr_q[INS_LOW_RES] |-> result_q[3:0] == LOW_RES_FILL)
        else $error("low nibble filler wrong");                          // R22
    short_cal_a: assert property (@(posedge clk) disable iff (reset)
        $rose(state_q == ST_CAL) && !config_q[CFG_FULL_CAL] |-> cnt_q == 21'd76)
        else $error("short calibration length wrong");                   // R10

endmodule : adc_instruction_sequencer

`default_nettype wire

/* host_bus_model.sv */
// host side of the sequencer register port: one-cycle write and read strobes
// assumes the shared 25 MHz clk; the slave never stalls the host
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire logic              clk,
    output var  seq_pkg::reg_req_t req,
    input  wire logic [15:0]       rdata
);
    import seq_pkg::*;

    initial req = '0;

    // one write strobe, released at the next edge so back-to-back calls never collide
    task automatic write_word(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : write_word

    // read data stands one cycle only; taken at the rising edge that closes that cycle
    task automatic read_word(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        d = rdata;
    endtask : read_word
endmodule : host_bus_model
`default_nettype wire

/* adc_instruction_sequencer_tb_top.sv */
// self-checking bench: state walk durations, pointer status and result coding
// assumes host_bus_model drives the register port; full calibration shortened
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module adc_instruction_sequencer_tb_top;
    import seq_pkg::*;
    typedef logic [15:0] seg_t;
    localparam int CAL_N = 20;   // short full-calibration count keeps the run brief
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic signed [15:0] conv_code = 16'sh0000;
    reg_req_t          req;
    logic [15:0]       rdata;
    logic [2:0]        state_out;
    logic              convert_done;
    int                err_count = 0;
    int                comparisons = 0;
    int                dones = 0;
    int                run = 0;
    bit                armed = 1'b0;
    logic [2:0]        last_st = 3'h0;
    logic [15:0]       r;
    seg_t              walk[$];

    always #20 clk = ~clk;

    adc_instruction_sequencer #(.CAL_FULL_CYCLES(CAL_N)) dut_u (
        .clk(clk), .reset(reset), .req(req), .conv_code(conv_code),
        .rdata(rdata), .state_out(state_out), .convert_done(convert_done));
    host_bus_model host_u (.clk(clk), .req(req), .rdata(rdata));

    // cut the state trace into {state, cycles}; recording starts at a fetch
    always @(posedge clk) begin
        if (convert_done === 1'b1) dones++;
        if (state_out !== last_st) begin
            if (armed || last_st == ST_FETCH) begin
                armed = 1'b1;
                walk.push_back({last_st, 13'(run)});
            end
            run = 1;
        end else begin
            run++;
        end
        last_st = state_out;
    end

    // expected walk of one instruction, ending with the next fetch
    function automatic void exp_walk(input logic [15:0] ins, input logic [15:0] cfg,
                                     input logic [15:0] tmr, output seg_t q[$]);
        int d;
        bit low;
        d = int'(ins[15:12]);
        low = ins[INS_LOW_RES] | ins[INS_COMPARE];
        q = {};
        q.push_back({ST_FETCH, 13'(CYC_FETCH)});
        q.push_back({ST_CHECK, 13'(CYC_CHECK)});
        if (cfg[CFG_FULL_CAL]) q.push_back({ST_CAL, 13'(CAL_N)});
        else if (cfg[CFG_SHORT_A] | cfg[CFG_SHORT_B]) q.push_back({ST_CAL, 13'(CYC_CAL_SHORT)});
        if (ins[INS_TIMER_EN]) q.push_back({ST_TIMER, 13'(TMR_SCALE * int'(tmr) + TMR_EXTRA)});
        q.push_back({ST_ACQ, 13'((low ? ACQ_LOW_BASE : ACQ_FULL_BASE) + 2 * d)});
        if (ins[INS_COMPARE]) begin
            q.push_back({ST_CMP, 13'(CYC_CMP)});
            q.push_back({ST_LIM2, 13'(CYC_LIM2)});
            q.push_back({ST_CONV, 13'(CYC_CMP)});
        end else begin
            q.push_back({ST_CONV, 13'(ins[INS_LOW_RES] ? CYC_CONV_LOW : CYC_CONV_FULL)});
        end
        q.push_back({ST_FETCH, 13'(CYC_FETCH)});
    endfunction : exp_walk

    function automatic logic [15:0] exp_full(input logic signed [15:0] c);
        if (c > 16'sd4095) return 16'h0FFF;
        if (c < -16'sd4096) return 16'hF000;
        return c;
    endfunction : exp_full

    // reduced resolution: clamp to nine bits, filler nibble, sign extended
    function automatic logic [15:0] exp_low(input logic signed [15:0] c);
        logic signed [15:0] v;
        v = c;
        if (v > 16'sd255) v = 16'sd255;
        if (v < -16'sd256) v = -16'sd256;
        return {{3{v[8]}}, v[8:0], LOW_RES_FILL};
    endfunction : exp_low

    // one instruction from a soft reset; entry 1 pauses so a non-looping walk ends at rest, a looping one is stopped by clearing start
    task automatic run_case(input logic [15:0] ins, input logic [15:0] cfg,
                            input logic [15:0] tmr, input logic signed [15:0] code);
        seg_t q[$];
        int   k;
        int   n0;
        conv_code <= code;
        host_u.write_word(OFS_TIMER, tmr);
        host_u.write_word(OFS_INSTR, ins);
        host_u.write_word(OFS_INSTR + 4'h1, 16'h0001);
        host_u.write_word(OFS_CONFIG, cfg | 16'h0003);
        walk.delete();
        armed = 1'b0;
        n0 = dones;
        exp_walk(ins, cfg, tmr, q);
        for (k = 0; k < 4000 && walk.size() < q.size(); k++) @(posedge clk);
        foreach (q[i]) `CHK(walk[i], q[i])
        if (ins[INS_LOOP]) begin
            host_u.write_word(OFS_CONFIG, 16'h0000);
            for (k = 0; k < 400 && state_out !== ST_CHECK; k++) @(posedge clk);
        end
        host_u.read_word(OFS_STATUS, r);
        `CHK(r, {5'h00, ins[INS_LOOP] ? 3'h0 : 3'h1, 5'h00, ST_CHECK})
        if (!ins[INS_COMPARE]) begin
            host_u.read_word(OFS_RESULT, r);
            if (ins[INS_LOW_RES]) begin
                `CHK(r[3:0], LOW_RES_FILL)
                `CHK(r, exp_low(code))
            end else begin
                `CHK(r, exp_full(code))
            end
            if (!ins[INS_LOOP]) `CHK(dones - n0, 1)
        end
    endtask : run_case

    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // watchdog: the whole sequence needs well under this many cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h0B55));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        host_u.read_word(OFS_STATUS, r);
        `CHK(r, {13'h0000, ST_CHECK})
        host_u.read_word(4'h4, r);
        `CHK(r, 16'h0000)
        run_case(16'h5000, 16'h0000, 16'h0000, 16'sh7FFF);
        run_case(16'hF300, 16'h0000, 16'h0003, -16'sd32768);
        run_case(16'hA800, 16'h0000, 16'h0000, 16'sh0000);
        run_case(16'h0000, 16'h0004, 16'h0000, 16'sd4095);
        run_case(16'h0000, 16'h0040, 16'h0000, -16'sd4096);
        run_case(16'h0000, 16'h0008, 16'h0000, 16'sd4096);
        run_case(16'h3002, 16'h0000, 16'h0000, 16'sh0123);
        repeat (8) run_case({4'($urandom), 1'($urandom), 1'b0, 1'($urandom), 1'($urandom), 8'h00},
                            {9'h000, 1'($urandom), 2'b00, 1'($urandom), 1'($urandom), 2'b00},
                            16'($urandom_range(7)), 16'($urandom));
        stop_test();
    end
endmodule : adc_instruction_sequencer_tb_top
`default_nettype wire
